/* File: pbsp_regs.vh */
// constants and command codes for the pci bus signal protocol block
// What this block does
// - first clock carries address, later clocks data
// - burst reads and writes under one address
// - address phase command on c_be lines
// - data phase byte enables, bit n lane n
// - parity even over ad, c_be, par
// - parity covers read data/enables only, not address/command
// - frame deasserted marks final phase or idle
// - phase completes when irdy and trdy asserted
// - wait whenever irdy and trdy not both
// - reads: trdy only with valid data
// - writes: trdy only when ready to accept
// - target stop asks master to end
// - devsel asserted after own address decode
// - configuration cycles select by idsel only
// - everything sampled on rising clock edge
// - reset floats outputs, clears logic, synchronised
// - names ending _n are active low
`ifndef PBSP_REGS_VH
`define PBSP_REGS_VH
`define PBSP_CMD_IO_RD   4'h2
`define PBSP_CMD_IO_WR   4'h3
`define PBSP_CMD_MEM_RD  4'h6
`define PBSP_CMD_MEM_WR  4'h7
`define PBSP_CMD_CFG_RD  4'hA
`define PBSP_CMD_CFG_WR  4'hB
`define PBSP_CMD_MRM     4'hC
`define PBSP_CMD_MRL     4'hE
`define PBSP_CMD_MWI     4'hF
`define PBSP_DEC_LSB     8
`define PBSP_CMD_WR_BIT  0
`define PBSP_ADDR_STEP   32'h4
`define PBSP_LANES       4
`endif

/* File: pbsp_parity.v */
// registered even parity generator for the ad and c_be lines
`timescale 1ns/1ps
module pbsp_parity (
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  input  wire [31:0] ad_i,
  input  wire [3:0]  cbe_i,
  input  wire        en_i,
  output reg         par_o,
  output reg         par_oe_o
);
  // ---------------------------------------------
  // parity one clock behind its data
  // ---------------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      par_o    <= 1'b0;
      par_oe_o <= 1'b0;
    end else begin
      par_o    <= ^{ad_i, cbe_i};
      par_oe_o <= en_i;
    end
  end
endmodule // pbsp_parity

/* File: pbsp_target.v */
// pci target side: decode, handshake, data transfer to user side
`timescale 1ns/1ps
`include "pbsp_regs.vh"
module pbsp_target #(
  parameter BASE_W = 24
) (
  input  wire              clk_sys_i,
  input  wire              resetn_i,
  input  wire [31:0]       ad_i,
  output reg  [31:0]       ad_o,
  output reg               ad_oe_o,
  input  wire [3:0]        cbe_n_i,
  output wire              par_o,
  output wire              par_oe_o,
  input  wire              frame_n_i,
  input  wire              irdy_n_i,
  output reg               trdy_n_o,
  output reg               stop_n_o,
  output reg               devsel_n_o,
  output reg               ctl_oe_o,
  input  wire              idsel_i,
  input  wire [BASE_W-1:0] base_i,
  output reg  [31:0]       usr_addr_o,
  output reg  [3:0]        usr_cmd_o,
  output reg               usr_cfg_o,
  output reg               usr_wr_o,
  output reg  [31:0]       usr_wdata_o,
  output reg  [3:0]        usr_be_o,
  output wire              usr_req_o,
  input  wire              usr_ack_i,
  input  wire [31:0]       usr_rdata_i,
  input  wire              usr_stop_i
);
  // ---------------------------------------------
  // reset release synchroniser
  // ---------------------------------------------
  // asserts at once, releases on the second rising edge
  reg        rst_meta_q;
  reg        rst_sync_q;
  wire       rst_n = rst_sync_q;

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------
  // states
  // ---------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DATA = 5'h02;
  localparam [4:0] ST_TURN = 5'h04;
  localparam [4:0] ST_SKIP = 5'h08;
  localparam [4:0] ST_BKOF = 5'h10;

  reg  [4:0] st_q;
  reg        frame_q;
  reg        rdv_q;
  wire [3:0] be_act;

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  localparam DEC_LSB = 32 - BASE_W;

  wire       frame   = ~frame_n_i;
  wire       irdy    = ~irdy_n_i;
  wire       start   = frame & ~frame_q;
  wire [3:0] cmd     = cbe_n_i;
  wire       is_cfg  = (cmd == `PBSP_CMD_CFG_RD) |
                       (cmd == `PBSP_CMD_CFG_WR);
  wire       is_mem  = (cmd == `PBSP_CMD_MEM_RD) |
                       (cmd == `PBSP_CMD_MEM_WR) |
                       (cmd == `PBSP_CMD_MRM) |
                       (cmd == `PBSP_CMD_MRL) |
                       (cmd == `PBSP_CMD_MWI);
  wire       hit_mem = is_mem & (ad_i[31:DEC_LSB] == base_i);
  wire       hit_cfg = is_cfg & idsel_i;
  wire       done    = (st_q == ST_DATA) & irdy & ~trdy_n_o;
  wire       rd_ok   = ~usr_wr_o & rdv_q;
  wire       wr_ok   = usr_wr_o & irdy;

  // ---------------------------------------------
  // byte lane enables, active high
  // ---------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PBSP_LANES; g = g + 1) begin : g_lane
      assign be_act[g] = ~cbe_n_i[g];
    end
  endgenerate

  // ---------------------------------------------
  // frame edge detect
  // ---------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n)
      frame_q <= 1'b0;
    else
      frame_q <= frame;
  end

  // ---------------------------------------------
  // user request
  // ---------------------------------------------
  // write needs master data, read needs a free slot
  assign usr_req_o = (st_q == ST_DATA) & trdy_n_o & stop_n_o &
                     (usr_wr_o ? irdy : ~rdv_q);

  // ---------------------------------------------
  // parity
  // ---------------------------------------------
  pbsp_parity u_par (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (rst_n),
    .ad_i      (ad_o),
    .cbe_i     (cbe_n_i),
    .en_i      (ad_oe_o),
    .par_o     (par_o),
    .par_oe_o  (par_oe_o)
  );

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= ST_IDLE;
      rdv_q       <= 1'b0;
      ad_o        <= 32'h0;
      ad_oe_o     <= 1'b0;
      trdy_n_o    <= 1'b1;
      stop_n_o    <= 1'b1;
      devsel_n_o  <= 1'b1;
      ctl_oe_o    <= 1'b0;
      usr_addr_o  <= 32'h0;
      usr_cmd_o   <= 4'h0;
      usr_cfg_o   <= 1'b0;
      usr_wr_o    <= 1'b0;
      usr_wdata_o <= 32'h0;
      usr_be_o    <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start & (hit_mem | hit_cfg)) begin
            usr_addr_o <= ad_i;
            usr_cmd_o  <= cmd;
            usr_cfg_o  <= is_cfg;
            usr_wr_o   <= cmd[`PBSP_CMD_WR_BIT];
            devsel_n_o <= 1'b0;
            ctl_oe_o   <= 1'b1;
            ad_oe_o    <= ~cmd[`PBSP_CMD_WR_BIT];
            rdv_q      <= 1'b0;
            st_q       <= ST_DATA;
          end else if (start) begin
            st_q <= ST_SKIP;
          end
        end
        ST_DATA: begin
          if (done) begin
            trdy_n_o <= 1'b1;
            rdv_q    <= 1'b0;
            if (usr_wr_o) begin
              usr_wdata_o <= ad_i;
              usr_be_o    <= be_act;
            end
            if (!frame) begin
              devsel_n_o <= 1'b1;
              stop_n_o   <= 1'b1;
              ad_oe_o    <= 1'b0;
              st_q       <= ST_TURN;
            end else begin
              usr_addr_o <= usr_addr_o + `PBSP_ADDR_STEP;
            end
          end else if (!stop_n_o) begin
            trdy_n_o <= 1'b1;
            if (!frame) begin
              devsel_n_o <= 1'b1;
              stop_n_o   <= 1'b1;
              ad_oe_o    <= 1'b0;
              st_q       <= ST_TURN;
            end
          end else if (usr_stop_i & trdy_n_o) begin
            stop_n_o <= 1'b0;
          end else if (usr_req_o & usr_ack_i) begin
            if (!usr_wr_o) begin
              ad_o  <= usr_rdata_i;
              rdv_q <= 1'b1;
            end
            if (usr_wr_o)
              usr_be_o <= be_act;
            trdy_n_o <= ~(usr_wr_o ? wr_ok : 1'b1);
          end
        end
        ST_TURN: begin
          // one turnaround clock before letting go of the control lines
          ctl_oe_o <= 1'b0;
          st_q     <= ST_IDLE;
        end
        ST_SKIP: begin
          // another agent's cycle: wait for an idle bus
          if (!frame & !irdy)
            st_q <= ST_IDLE;
        end
        ST_BKOF: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      if (!usr_wr_o & rd_ok & (st_q == ST_DATA) & trdy_n_o & stop_n_o)
        trdy_n_o <= 1'b0;
    end
  end
endmodule // pbsp_target

/* File: pbsp_assertions.sv */
// port checks for the pci target
`timescale 1ns/1ps
module pbsp_chk #(parameter BASE_W = 24) (
  input wire [31:0]       ad_i,
  input wire [31:0]       ad_o,
  input wire [3:0]        cbe_n_i,
  input wire [BASE_W-1:0] base_i,
  input wire [31:0]       usr_wdata_o,
  input wire              clk_sys_i, resetn_i, ad_oe_o, par_o, par_oe_o, frame_n_i, irdy_n_i,
  input wire              trdy_n_o, stop_n_o, devsel_n_o, ctl_oe_o, idsel_i, usr_wr_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  par_lag_a: assert property (par_oe_o == $past(ad_oe_o)) else $error("par lag");
  par_even_a: assert property ($past(ad_oe_o) |-> !(^{par_o, $past(ad_o), $past(cbe_n_i)})) else $error("par");
  rd_valid_a: assert property (!trdy_n_o && !usr_wr_o |-> ad_oe_o) else $error("rd data");
  ctl_own_a: assert property (!devsel_n_o || !trdy_n_o |-> ctl_oe_o) else $error("ctl oe");
  cfg_sel_a: assert property ($fell(frame_n_i) && idsel_i && cbe_n_i[3:1] == 3'h5 |=> !devsel_n_o)
    else $error("cfg sel");
  addr_miss_a: assert property ($fell(frame_n_i) && !idsel_i && ad_i[31:32-BASE_W] != base_i |=> devsel_n_o)
    else $error("miss");
  wr_cap_a: assert property (!irdy_n_i && !trdy_n_o && usr_wr_o |=> usr_wdata_o == $past(ad_i))
    else $error("wdata");
  stop_nodata_a: assert property (!stop_n_o |-> trdy_n_o) else $error("stop");
  rst_float_a: assert property (disable iff (1'b0) !resetn_i |-> !ad_oe_o && !ctl_oe_o) else $error("rst");
endmodule // pbsp_chk
bind pbsp_target pbsp_chk #(.BASE_W(BASE_W)) pbsp_chk_inst (.*);

/* File: pbsp_mst_model.sv */
// pci master model facing the target
`timescale 1ns/1ps
module pbsp_mst_model (
  input  wire        clk_sys_i,
  input  wire [31:0] ad_i,
  input  wire        trdy_n_i,
  input  wire        stop_n_i,
  output reg  [31:0] ad_o,
  output reg  [3:0]  cbe_n_o,
  output reg         frame_n_o,
  output reg         irdy_n_o
);
  logic [31:0] got[$];
  logic [31:0] sent[$];
  int          done;
  initial {ad_o, cbe_n_o, frame_n_o, irdy_n_o} = {32'h0, 6'h3F};
  task automatic xfer(input [3:0] cmd, input [31:0] adr, input int n, input bit slow);
    int t, lim;
    bit w;
    done = 0;
    t = 0;
    lim = 16 * n + 16;
    @(posedge clk_sys_i);
    frame_n_o <= 1'b0;
    ad_o <= adr;
    cbe_n_o <= cmd;
    while (t < lim) begin
      @(posedge clk_sys_i);
      t++;
      w = slow && (t % 3 != 0);
      if (!irdy_n_o && !trdy_n_i) begin
        if (cmd[0]) sent.push_back(ad_o);
        else got.push_back(ad_i);
        done++;
      end
      if (!stop_n_i || done == n) t = lim;
      else if (irdy_n_o || !trdy_n_i) begin
        irdy_n_o <= w;
        frame_n_o <= (done == n - 1) && !w;
        ad_o <= cmd[0] ? adr + t * 32'h01010101 : ~ad_o;
        cbe_n_o <= done[3:0] ^ 4'h5;
      end
    end
    irdy_n_o <= 1'b1;
    frame_n_o <= 1'b1;
    cbe_n_o <= 4'hF;
    ad_o <= ~ad_o;
    @(posedge clk_sys_i);
  endtask
endmodule // pbsp_mst_model

/* File: tb.sv */
// testbench for the pci target
`timescale 1ns/1ps
`include "pbsp_regs.vh"
module tb;
  reg  [31:0]  usr_rdata_i = 32'h0;
  reg  [31:0]  seed;
  reg  [31:0]  ea = 32'h0;
  reg  [23:0]  base_i;
  reg  [3:0]   ec = 4'h0;
  reg  [3:0]   eb = 4'h0;
  reg          clk_sys_i, resetn_i, idsel_i, usr_stop_i;
  reg          usr_ack_i = 1'b0;
  reg          wc = 1'b0;
  reg          mf_q = 1'b1;
  wire [31:0]  ad_o, m_ad, usr_wdata_o, usr_addr_o;
  wire [3:0]   m_cbe, usr_cmd_o, usr_be_o;
  wire         ad_oe_o, m_frame, m_irdy, trdy_n_o, stop_n_o, usr_req_o, usr_wr_o, usr_cfg_o;
  wire [31:0]  ad_w = ad_oe_o ? ad_o : m_ad;
  logic [31:0] rq[$];
  bit [3:0]    cm[5] = '{`PBSP_CMD_MEM_RD, `PBSP_CMD_MEM_WR, `PBSP_CMD_MRM, `PBSP_CMD_MRL, `PBSP_CMD_MWI};
  int          failures, n_compared, cyc, i, nph;
  pbsp_target pbsp_target_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ad_i(ad_w), .ad_o(ad_o),
    .ad_oe_o(ad_oe_o), .cbe_n_i(m_cbe), .par_o(), .par_oe_o(), .frame_n_i(m_frame), .irdy_n_i(m_irdy),
    .trdy_n_o(trdy_n_o), .stop_n_o(stop_n_o), .devsel_n_o(), .ctl_oe_o(), .idsel_i(idsel_i), .base_i(base_i),
    .usr_addr_o(usr_addr_o), .usr_cmd_o(usr_cmd_o), .usr_cfg_o(usr_cfg_o), .usr_wr_o(usr_wr_o),
    .usr_wdata_o(usr_wdata_o), .usr_be_o(usr_be_o), .usr_req_o(usr_req_o), .usr_ack_i(usr_ack_i),
    .usr_rdata_i(usr_rdata_i), .usr_stop_i(usr_stop_i));
  pbsp_mst_model pbsp_mst_model_inst (.clk_sys_i(clk_sys_i), .ad_i(ad_w), .trdy_n_i(trdy_n_o),
    .stop_n_i(stop_n_o), .ad_o(m_ad), .cbe_n_o(m_cbe), .frame_n_o(m_frame), .irdy_n_o(m_irdy));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (e !== s) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task run(input [3:0] c, input [31:0] a, input int n, input bit slow, input int x);
    rq.delete();
    pbsp_mst_model_inst.xfer(c, a, n, slow);
    @(posedge clk_sys_i);
    chk("phases", x, pbsp_mst_model_inst.done);
    while (pbsp_mst_model_inst.got.size() > 0) chk("rdata", rq.pop_front(), pbsp_mst_model_inst.got.pop_front());
    $display("test cmd %h len %0d done", c, n);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (usr_req_o && usr_ack_i && !usr_wr_o) rq.push_back(usr_rdata_i);
    if (wc) chk("wdata", pbsp_mst_model_inst.sent.pop_front(), usr_wdata_o);
    if (wc) chk("be", eb, usr_be_o);
    wc <= !m_irdy && !trdy_n_o && usr_wr_o;
    mf_q <= m_frame;
    if (mf_q && !m_frame) begin
      ea <= m_ad;
      ec <= m_cbe;
      nph <= 0;
    end
    if (!m_irdy && !trdy_n_o) begin
      chk("addr", ea + 32'h4 * nph, usr_addr_o);
      chk("cmd", ec, usr_cmd_o);
      chk("cfg", ec == `PBSP_CMD_CFG_RD || ec == `PBSP_CMD_CFG_WR, usr_cfg_o);
      eb <= ~m_cbe;
      nph <= nph + 1;
    end
    usr_rdata_i <= $random(seed);
    usr_ack_i <= seed[2] | seed[5];
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    seed = 32'h7FFBB9AC;
    {resetn_i, idsel_i, usr_stop_i} = '0;
    base_i = 24'h3C5A81;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i); // release passes an internal synchroniser
    for (i = 0; i < 10; i++) run(cm[i % 5], {base_i, 8'h40}, 1 + i % 4, i > 4, 1 + i % 4);
    run(`PBSP_CMD_MEM_RD, {~base_i, 8'h40}, 1, 0, 0);
    idsel_i <= 1'b1;
    run(`PBSP_CMD_CFG_WR, {~base_i, 8'h10}, 1, 0, 1);
    run(`PBSP_CMD_CFG_RD, {~base_i, 8'h10}, 1, 1, 1);
    idsel_i <= 1'b0;
    run(`PBSP_CMD_CFG_RD, {base_i, 8'h10}, 1, 0, 0);
    usr_stop_i <= 1'b1;
    run(`PBSP_CMD_MEM_WR, {base_i, 8'h80}, 2, 0, 0);
    usr_stop_i <= 1'b0;
    run(`PBSP_CMD_MEM_WR, {base_i, 8'h00}, 4, 1, 4);
    give_verdict;
  end
endmodule // tb
